// file: hs_slot_pkg.sv
// Purpose: Shared constants and types for the hot-swap slot signal controller.
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes:   Select output, reset and healthy vectors hold pin levels, so a set bit means the signal is deasserted.
package hs_slot_pkg;

   localparam int ADDR_W = 8;
   localparam int SLOTS  = 8;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_BOOT   = 8'h04;
   localparam logic [7:0] OFF_STATE  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_MASK   = 8'h10;
   localparam logic [7:0] OFF_OUT    = 8'h14;

   // One-hot register select positions.
   localparam int SEL_CTRL   = 0;
   localparam int SEL_BOOT   = 1;
   localparam int SEL_STATE  = 2;
   localparam int SEL_STATUS = 3;
   localparam int SEL_MASK   = 4;
   localparam int SEL_OUT    = 5;
   localparam int SEL_W      = 6;

   // Control register fields.
   localparam int CTRL_OWNER_BIT = 0;
   localparam int CTRL_PWRON_BIT = 1;

   // Byte lanes of the signal state word.
   localparam int LANE_BDSEL   = 0;
   localparam int LANE_HEALTHY = 1;
   localparam int LANE_RESET   = 2;
   localparam int LANE_OCC     = 3;

   // Status and mask layout.
   localparam int STS_ERR_LSB = 0;
   localparam int STS_CHG_LSB = 8;
   localparam int STS_W       = 16;

   // Slot masks: bits 1..6 are controllable slots 3..8.
   localparam logic [7:0] SLOT_CTRL_MASK = 8'h7e;
   localparam logic [7:0] BDSEL_FIXED    = 8'h80;
   localparam logic [7:0] RST_FIXED      = 8'h01;

   // Reset values.
   localparam logic       OWNER_RST     = 1'b0;
   localparam logic [7:0] BOOT_RST      = 8'hff;
   localparam logic [7:0] BDSEL_VEC_RST = 8'hff;
   localparam logic [7:0] RST_VEC_RST   = 8'h00;
   localparam logic [7:0] PIN_IDLE      = 8'hff;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [7:0] occupancy;
      logic [7:0] reset;
      logic [7:0] healthy;
      logic [7:0] bdsel;
   } signal_state_record_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_t;

   // Legal per-slot combinations of {request, healthy, reset, occupancy}.
   function automatic logic validSlotState(input logic [3:0] s);
      case (s)
         4'h4, 4'hd, 4'h5, 4'h1, 4'h3, 4'h7: validSlotState = 1'b1;
         default: validSlotState = 1'b0;
      endcase
   endfunction

endpackage

// file: sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for a vector of pin inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module sync_two_ff #(
   parameter int         W    = 8,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,     // System clock.
   input  wire logic         sys_rst, // Synchronous reset, active high.
   input  wire logic         ce,      // Clock enable.
   input  wire logic [W-1:0] din,     // Asynchronous input.
   output logic      [W-1:0] dout     // Synchronised output.
);
   logic [W-1:0] stage1_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_r <= INIT;
         dout     <= INIT;
      end else if (ce) begin
         stage1_r <= din;
         dout     <= stage1_r;
      end
   end
endmodule // sync_two_ff

// file: hot_swap_slot_signal_ctrl.sv
// Purpose: Per-slot board-select and reset control with healthy and occupancy reporting.
// Assumes: Slot pins are asynchronous; one clock; AXI4-Lite register access.
// Notes:   Output vectors are pin levels of the active-low slot lines.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// How it works
// R1: Owner bit resets to 0, management controller drives slots; 1 hands them to software.
// R2: Boot power mask acts only while the owner bit is 1.
// R3: Power-on event loads the 8-bit mask: 0 powers the slot, 1 keeps it off.
// R4: Bits 1..6 are slots 3..8; bit 7 unused; bit 0 not controllable.
// R5: System controller slot is always selected and out of reset; while sys_rst is high the code deselects it and holds it in reset.
// R6: One 8-bit vector per signal covers all slots; host slots excluded.
// R7: A set vector bit means the signal is deasserted, clear means asserted.
// R8: Clear reset bit keeps the board in reset until software sets it.
// R9: Written board-select bit 1 deasserts the select line, 0 asserts it.
// R10: Read board-select bits show slots requesting select.
// R11: Occupancy reads 0 for an empty slot and 1 for an occupied one.
// R12: Only select and reset vectors are writable; healthy and occupancy ignored.
// R13: One read returns all four vectors; one write sets select and reset together.
// R14: Software should set the boot mask to all ones to control every slot.
// R15: Software releases reset only after the healthy bit reads clear.
// R16: Undocumented per-slot signal combinations flag an error for that slot.
// R17: Healthy and select request pins are synchronised before being reported.
// R18: After reset every controllable slot is deselected and held in reset; with owner bit 0 the code selects occupied slots once presence is synced.
module hot_swap_slot_signal_ctrl #(
   parameter int ADDR_W = hs_slot_pkg::ADDR_W
) (
   input  wire logic              clk,          // System clock, 200 MHz.
   input  wire logic              sys_rst,      // Synchronous reset, active high.
   input  wire logic              ce,           // Clock enable; low freezes all state.
   input  wire logic [ADDR_W-1:0] awaddr,       // Write address.
   input  wire logic              awvalid,      // Write address valid.
   output logic                   awready,      // Write address ready.
   input  wire logic [31:0]       wdata,        // Write data.
   input  wire logic [3:0]        wstrb,        // Write byte strobes.
   input  wire logic              wvalid,       // Write data valid.
   output logic                   wready,       // Write data ready.
   output logic [1:0]             bresp,        // Write response.
   output logic                   bvalid,       // Write response valid.
   input  wire logic              bready,       // Write response ready.
   input  wire logic [ADDR_W-1:0] araddr,       // Read address.
   input  wire logic              arvalid,      // Read address valid.
   output logic                   arready,      // Read address ready.
   output logic [31:0]            rdata,        // Read data.
   output logic [1:0]             rresp,        // Read response.
   output logic                   rvalid,       // Read data valid.
   input  wire logic              rready,       // Read data ready.
   input  wire logic [7:0]        slotReqN,     // Board select request pins, low requests.
   input  wire logic [7:0]        healthyN,     // Board healthy pins, low is healthy.
   input  wire logic [7:0]        presentN,     // Board present pins, low is occupied.
   input  wire logic              chassisPwrOn, // Chassis power-on level, rising edge acts.
   output logic [7:0]             bdselN,       // Board select outputs, active low.
   output logic [7:0]             slotRstN,     // Slot reset outputs, active low.
   output logic                   irq           // Interrupt, active high level.
);

   logic [7:0] reqNSync;
   logic [7:0] healthySync;
   logic [7:0] presentNSync;
   logic       pwrOnSync;
   logic       pwrOnPrev_r;

   sync_two_ff #(.W(8), .INIT(hs_slot_pkg::PIN_IDLE)) uSyncReq (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .din     (slotReqN),
      .dout    (reqNSync)
   ); // R17
   sync_two_ff #(.W(8), .INIT(hs_slot_pkg::PIN_IDLE)) uSyncHealthy (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .din     (healthyN),
      .dout    (healthySync)
   ); // R17
   sync_two_ff #(.W(8), .INIT(hs_slot_pkg::PIN_IDLE)) uSyncPresent (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .din     (presentN),
      .dout    (presentNSync)
   );
   sync_two_ff #(.W(1), .INIT(1'b0)) uSyncPwr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .din     (chassisPwrOn),
      .dout    (pwrOnSync)
   );

   // Register select decoding shared by the read and write paths.
   function automatic logic [hs_slot_pkg::SEL_W-1:0] regSelect(input logic [ADDR_W-1:0] a);
      logic [7:0] off;
      off = 8'(a);
      regSelect = '0;
      if (a[1:0] == 2'b00) begin
         regSelect[hs_slot_pkg::SEL_CTRL]   = (off == hs_slot_pkg::OFF_CTRL);
         regSelect[hs_slot_pkg::SEL_BOOT]   = (off == hs_slot_pkg::OFF_BOOT);
         regSelect[hs_slot_pkg::SEL_STATE]  = (off == hs_slot_pkg::OFF_STATE);
         regSelect[hs_slot_pkg::SEL_STATUS] = (off == hs_slot_pkg::OFF_STATUS);
         regSelect[hs_slot_pkg::SEL_MASK]   = (off == hs_slot_pkg::OFF_MASK);
         regSelect[hs_slot_pkg::SEL_OUT]    = (off == hs_slot_pkg::OFF_OUT);
      end
   endfunction

   // Software-visible state.
   logic                          owner_r;
   logic [7:0]                    bootMask_r;
   logic [7:0]                    swBdsel_r;
   logic [7:0]                    swRst_r;
   logic [hs_slot_pkg::STS_W-1:0] status_r;
   logic [hs_slot_pkg::STS_W-1:0] irqMask_r;
   logic [7:0]                    reqPrev_r;

   // Write channel state.
   hs_slot_pkg::wr_state_t wrState_r;
   hs_slot_pkg::wr_state_t wrState_nxt;
   logic                   awHeld_r;
   logic                   wHeld_r;
   logic [ADDR_W-1:0]      awAddr_r;
   logic [31:0]            wData_r;
   logic [3:0]             wStrb_r;

   // Read channel state.
   hs_slot_pkg::rd_state_t rdState_r;
   hs_slot_pkg::rd_state_t rdState_nxt;

   wire awFire = awvalid & awready;
   wire wFire  = wvalid & wready;
   wire arFire = arvalid & arready;
   wire wrDo   = awHeld_r & wHeld_r & (wrState_r == hs_slot_pkg::WR_IDLE);
   wire awHeldNxt = awFire | (awHeld_r & ~wrDo);
   wire wHeldNxt  = wFire | (wHeld_r & ~wrDo);

   wire [hs_slot_pkg::SEL_W-1:0] wrSel = regSelect(awAddr_r);
   wire [hs_slot_pkg::SEL_W-1:0] rdSel = regSelect(araddr);

   wire [31:0] byteMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

   // Vectors as software sees them.
   wire [7:0] reqVec     = ~reqNSync;     // R10
   wire [7:0] healthyVec = healthySync;   // R7
   wire [7:0] occVec     = ~presentNSync; // R11

   hs_slot_pkg::signal_state_record_t stateRec;
   assign stateRec.bdsel     = reqVec;    // R10
   assign stateRec.healthy   = healthyVec;
   assign stateRec.reset     = slotRstN;
   assign stateRec.occupancy = occVec;    // R13

   // Chassis power-on event from the pin edge or the control command bit.
   wire ctrlWr   = wrDo & wrSel[hs_slot_pkg::SEL_CTRL];
   wire cmdPwrOn = ctrlWr & wStrb_r[0] & wData_r[hs_slot_pkg::CTRL_PWRON_BIT];
   wire pwrOnEvt = (pwrOnSync & ~pwrOnPrev_r) | cmdPwrOn;
   wire bootLoad = pwrOnEvt & owner_r; // R2

   wire stateWr = wrDo & wrSel[hs_slot_pkg::SEL_STATE];
   wire bdselWr = stateWr & wStrb_r[hs_slot_pkg::LANE_BDSEL];
   wire rstWr   = stateWr & wStrb_r[hs_slot_pkg::LANE_RESET];
   wire [7:0] wBdsel = wData_r[8*hs_slot_pkg::LANE_BDSEL +: 8];
   wire [7:0] wRst   = wData_r[8*hs_slot_pkg::LANE_RESET +: 8];

   wire [7:0] bootBdsel = (swBdsel_r & ~hs_slot_pkg::SLOT_CTRL_MASK)
                        | (bootMask_r & hs_slot_pkg::SLOT_CTRL_MASK); // R3
   wire [7:0] swBdsel_nxt = bdselWr ? wBdsel : (bootLoad ? bootBdsel : swBdsel_r); // R9 R13
   wire [7:0] swRst_nxt   = rstWr ? wRst : swRst_r; // R8 R13

   // Management controller policy: select occupied slots, release once healthy.
   wire [7:0] autoBdsel = ~occVec;
   wire [7:0] autoRst   = ~healthyVec & ~autoBdsel;

   wire [7:0] baseBdsel = owner_r ? swBdsel_r : autoBdsel; // R1
   wire [7:0] baseRst   = owner_r ? swRst_r : autoRst;     // R1
   wire [7:0] bdselN_nxt = (baseBdsel & hs_slot_pkg::SLOT_CTRL_MASK)
                         | hs_slot_pkg::BDSEL_FIXED; // R4 R5
   wire [7:0] slotRstN_nxt = (baseRst & hs_slot_pkg::SLOT_CTRL_MASK)
                           | hs_slot_pkg::RST_FIXED; // R4 R5 R8

   // Per-slot error detection on controllable slots only.
   logic [7:0] errVec;
   genvar gi;
   generate
      for (gi = 0; gi < hs_slot_pkg::SLOTS; gi++) begin : gErr
         if (hs_slot_pkg::SLOT_CTRL_MASK[gi]) begin : gCheck
            assign errVec[gi] = ~hs_slot_pkg::validSlotState(
               {reqVec[gi], healthyVec[gi], slotRstN[gi], occVec[gi]}); // R16
         end else begin : gSkip
            assign errVec[gi] = 1'b0;
         end
      end
   endgenerate

   wire [7:0] chgVec = (reqVec ^ reqPrev_r) & hs_slot_pkg::SLOT_CTRL_MASK;
   wire [hs_slot_pkg::STS_W-1:0] stsEvt = {chgVec, errVec};
   wire stsWr = wrDo & wrSel[hs_slot_pkg::SEL_STATUS];
   wire [hs_slot_pkg::STS_W-1:0] stsClr = stsWr ? (wData_r[15:0] & byteMask[15:0]) : '0;
   // A new event in the clearing cycle keeps its bit set.
   wire [hs_slot_pkg::STS_W-1:0] status_nxt = (status_r & ~stsClr) | stsEvt;

   wire bootWr = wrDo & wrSel[hs_slot_pkg::SEL_BOOT] & wStrb_r[0];
   wire maskWr = wrDo & wrSel[hs_slot_pkg::SEL_MASK];
   wire [hs_slot_pkg::STS_W-1:0] irqMask_nxt =
      maskWr ? ((irqMask_r & ~byteMask[15:0]) | (wData_r[15:0] & byteMask[15:0])) : irqMask_r;
   wire owner_nxt = (ctrlWr & wStrb_r[0]) ? wData_r[hs_slot_pkg::CTRL_OWNER_BIT] : owner_r;

   // Read data selection; the state word returns all four vectors at once.
   wire [31:0] rdMux =
      rdSel[hs_slot_pkg::SEL_CTRL]   ? {31'h0, owner_r} :
      rdSel[hs_slot_pkg::SEL_BOOT]   ? {24'h0, bootMask_r} :
      rdSel[hs_slot_pkg::SEL_STATE]  ? stateRec :
      rdSel[hs_slot_pkg::SEL_STATUS] ? {16'h0, status_r} :
      rdSel[hs_slot_pkg::SEL_MASK]   ? {16'h0, irqMask_r} :
      rdSel[hs_slot_pkg::SEL_OUT]    ? {16'h0, slotRstN, bdselN} : 32'h0;
   wire rdHit = |rdSel;
   wire wrHit = |wrSel;

   always_comb begin
      wrState_nxt = wrState_r;
      case (wrState_r)
         hs_slot_pkg::WR_IDLE: if (wrDo) wrState_nxt = hs_slot_pkg::WR_RESP;
         hs_slot_pkg::WR_RESP: if (bready) wrState_nxt = hs_slot_pkg::WR_IDLE;
         default: wrState_nxt = hs_slot_pkg::WR_IDLE;
      endcase
   end

   always_comb begin
      rdState_nxt = rdState_r;
      case (rdState_r)
         hs_slot_pkg::RD_IDLE: if (arFire) rdState_nxt = hs_slot_pkg::RD_DATA;
         hs_slot_pkg::RD_DATA: if (rready) rdState_nxt = hs_slot_pkg::RD_IDLE;
         default: rdState_nxt = hs_slot_pkg::RD_IDLE;
      endcase
   end

   // Bus channel registers.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrState_r <= hs_slot_pkg::WR_IDLE;
         rdState_r <= hs_slot_pkg::RD_IDLE;
         awHeld_r  <= 1'b0;
         wHeld_r   <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         arready   <= 1'b0;
         bvalid    <= 1'b0;
         rvalid    <= 1'b0;
         bresp     <= hs_slot_pkg::RESP_OKAY;
         rresp     <= hs_slot_pkg::RESP_OKAY;
         rdata     <= 32'h0;
      end else if (ce) begin
         wrState_r <= wrState_nxt;
         rdState_r <= rdState_nxt;
         awHeld_r  <= awHeldNxt;
         wHeld_r   <= wHeldNxt;
         awready   <= ~awHeldNxt;
         wready    <= ~wHeldNxt;
         arready   <= (rdState_nxt == hs_slot_pkg::RD_IDLE);
         bvalid    <= (wrState_nxt == hs_slot_pkg::WR_RESP);
         rvalid    <= (rdState_nxt == hs_slot_pkg::RD_DATA);
         if (wrDo) begin
            bresp <= wrHit ? hs_slot_pkg::RESP_OKAY : hs_slot_pkg::RESP_SLVERR;
         end
         if (arFire) begin
            rdata <= rdMux;
            rresp <= rdHit ? hs_slot_pkg::RESP_OKAY : hs_slot_pkg::RESP_SLVERR;
         end
      end
   end

   // Captured write address and data.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awAddr_r <= '0;
         wData_r  <= 32'h0;
         wStrb_r  <= 4'h0;
      end else if (ce) begin
         if (awFire) awAddr_r <= awaddr;
         if (wFire) begin
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
      end
   end

   // Control, vectors, status and slot outputs.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         owner_r     <= hs_slot_pkg::OWNER_RST;     // R1
         bootMask_r  <= hs_slot_pkg::BOOT_RST;
         swBdsel_r   <= hs_slot_pkg::BDSEL_VEC_RST; // R18
         swRst_r     <= hs_slot_pkg::RST_VEC_RST;   // R18
         status_r    <= '0;
         irqMask_r   <= '0;
         reqPrev_r   <= 8'h0;
         pwrOnPrev_r <= 1'b0;
         bdselN      <= hs_slot_pkg::BDSEL_VEC_RST; // R18
         slotRstN    <= hs_slot_pkg::RST_VEC_RST;   // R18
         irq         <= 1'b0;
      end else if (ce) begin
         owner_r     <= owner_nxt;
         if (bootWr) bootMask_r <= wData_r[7:0];
         swBdsel_r   <= swBdsel_nxt;                // R12
         swRst_r     <= swRst_nxt;                  // R12
         status_r    <= status_nxt;
         irqMask_r   <= irqMask_nxt;
         reqPrev_r   <= reqVec;
         pwrOnPrev_r <= pwrOnSync;
         bdselN      <= bdselN_nxt;                 // R6 R7
         slotRstN    <= slotRstN_nxt;               // R6 R7
         irq         <= |(status_r & irqMask_r);
      end
   end

endmodule // hot_swap_slot_signal_ctrl

// file: hs_slot_ctrl_asserts.sv
// Purpose: Port checks for the slot signal controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every controller instance below.
`timescale 1ns/10ps
module hs_slot_ctrl_asserts #(
   parameter int ADDR_W = hs_slot_pkg::ADDR_W
) (
   input wire logic              clk,      // Clock.
   input wire logic              sys_rst,  // Reset.
   input wire logic              awvalid,  // AW valid.
   input wire logic              awready,  // AW ready.
   input wire logic              wvalid,   // W valid.
   input wire logic              wready,   // W ready.
   input wire logic [1:0]        bresp,    // Write response.
   input wire logic              bvalid,   // B valid.
   input wire logic              arvalid,  // AR valid.
   input wire logic              arready,  // AR ready.
   input wire logic [ADDR_W-1:0] araddr,   // Read address.
   input wire logic [31:0]       rdata,    // Read data.
   input wire logic [1:0]        rresp,    // Read response.
   input wire logic              rvalid,   // R valid.
   input wire logic [7:0]        bdselN,   // Select pins.
   input wire logic [7:0]        slotRstN, // Reset pins.
   input wire logic              irq       // Interrupt.
);
   default clocking cb @(posedge clk); endclocking
   // Slot two is forced one edge after release, so two clean cycles are required first.
   slot_two_fixed_a: assert property (disable iff (sys_rst)
      !$past(sys_rst) && !$past(sys_rst, 2) |-> !bdselN[0] && slotRstN[0])
      else $error("system slot not selected");
   unused_bit_a: assert property (disable iff (sys_rst)
      !$past(sys_rst) && !$past(sys_rst, 2) |-> bdselN[7] && !slotRstN[7])
      else $error("unused slot bit driven");
   reset_idle_a: assert property (
      sys_rst |=> bdselN[6:1] == 6'h3f && slotRstN[6:1] == 6'h00)
      else $error("slots not idle in reset");
   write_answer_a: assert property (disable iff (sys_rst)
      awvalid && awready && wvalid && wready |=> ##1 bvalid)
      else $error("write response late");
   write_free_a: assert property (disable iff (sys_rst)
      $rose(bvalid) |-> awready && wready)
      else $error("write slot not freed");
   read_answer_a: assert property (disable iff (sys_rst)
      arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   out_read_a: assert property (disable iff (sys_rst)
      arvalid && arready && araddr == hs_slot_pkg::OFF_OUT
      |=> rdata == {16'h0000, $past(slotRstN), $past(bdselN)})
      else $error("pin readback differs from pins");
   irq_clear_a: assert property (disable iff (sys_rst)
      $fell(irq) |-> $past(bvalid))
      else $error("interrupt dropped without a write");
   cover property (bvalid && bresp == hs_slot_pkg::RESP_SLVERR);
   cover property ($rose(irq));
   cover property (rvalid && rresp == hs_slot_pkg::RESP_OKAY);
endmodule // hs_slot_ctrl_asserts

bind hot_swap_slot_signal_ctrl hs_slot_ctrl_asserts #(.ADDR_W(ADDR_W)) chkU (
   .clk(clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
   .araddr(araddr), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .bdselN(bdselN),
   .slotRstN(slotRstN), .irq(irq));

// file: hs_board_model.sv
// Purpose: Plug-in boards seen from the slot pins.
// Assumes: Healthy lines are pulled up when no board drives them.
// Notes:   A selected board turns healthy after healthDelay cycles unless sick.
`timescale 1ns/10ps
module hs_board_model (
   input  wire logic       clk,         // Clock.
   input  wire logic [7:0] bdselN,      // Select pins.
   input  wire logic [7:0] present,     // Board fitted.
   input  wire logic [7:0] sick,        // Board never healthy.
   input  wire logic [7:0] healthDelay, // Power-up cycles.
   output logic      [7:0] slotReqN,    // Select request.
   output logic      [7:0] healthyN,    // Healthy pins.
   output logic      [7:0] presentN     // Present pins.
);
   logic [7:0] upCnt [8];
   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (!present[i] || bdselN[i]) begin
            upCnt[i] <= 8'h00;
         end else if (upCnt[i] != 8'hff) begin
            upCnt[i] <= upCnt[i] + 8'h01;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         presentN[i] = ~present[i];
         slotReqN[i] = ~(present[i] & bdselN[i]);
         healthyN[i] = ~(present[i] && !bdselN[i] && !sick[i] && upCnt[i] >= healthDelay);
      end
   end
endmodule // hs_board_model

// file: tb_hot_swap_slot_signal_ctrl.sv
// Purpose: Self-checking bench for the slot signal controller.
// Assumes: bready and rready stay high; boards answer on the slot pins.
// Notes:   Bus results are noted in queues and compared as they return.
`timescale 1ns/10ps
module tb_hot_swap_slot_signal_ctrl;
   typedef struct packed {
      logic [31:0] val;
      logic [31:0] msk;
      logic [1:0]  resp;
   } note_t;
   logic        clk, awready, wready, bvalid, arready, rvalid, irq;
   logic        ce = 1'b1, bready = 1'b1, rready = 1'b1, sys_rst = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, chassisPwrOn = 1'b0;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb = 4'hf;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sick = 8'h00, healthDelay = 8'h1e;
   logic [7:0]  present = 8'h19, swB = 8'hff, swR = 8'h00, boot;
   logic [7:0]  slotReqN, healthyN, presentN, bdselN, slotRstN;
   logic [31:0] wdata = 32'h0, rdata, rnd;
   note_t       rq[$];
   logic [1:0]  wq[$];
   int          num_errors = 0;
   int          checked = 0;
   int          seed = 24635;

   hot_swap_slot_signal_ctrl dut_u (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .slotReqN(slotReqN), .healthyN(healthyN), .presentN(presentN),
      .chassisPwrOn(chassisPwrOn), .bdselN(bdselN), .slotRstN(slotRstN), .irq(irq));
   hs_board_model boardU (
      .clk(clk), .bdselN(bdselN), .present(present), .sick(sick),
      .healthDelay(healthDelay), .slotReqN(slotReqN), .healthyN(healthyN),
      .presentN(presentN));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   always @(posedge clk) begin
      note_t n;
      if (rvalid && rready) begin
         n = rq.pop_front();
         cmp("rdata", n.val & n.msk, rdata & n.msk);
         cmp("rresp", {30'h0, n.resp}, {30'h0, rresp});
      end
      if (bvalid && bready) begin
         cmp("bresp", {30'h0, wq[0]}, {30'h0, bresp});
         void'(wq.pop_front());
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                     input logic [1:0] r = hs_slot_pkg::RESP_OKAY);
      logic aw = 1'b0, w = 1'b0;
      wq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         aw = aw | awready;
         w = w | wready;
         awvalid <= !aw;
         wvalid <= !w;
      end
      do @(posedge clk); while (!bvalid);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = '1,
                     input logic [1:0] r = hs_slot_pkg::RESP_OKAY);
      rq.push_back('{v, m, r});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
   endtask

   function automatic logic [31:0] stExp(input logic [7:0] b, input logic [7:0] r);
      stExp = {present, r, ~(present & ~b & ~sick), present & b};
   endfunction

   // Expected pins: software vectors when sw is set, else the automatic policy.
   task automatic chkPins(input logic sw);
      logic [7:0] b, r;
      b = sw ? {1'b1, swB[6:1], 1'b0} : {1'b1, ~present[6:1], 1'b0};
      r = sw ? {1'b0, swR[6:1], 1'b1} : {1'b0, present[6:1] & ~sick[6:1], 1'b1};
      repeat (60) @(posedge clk);
      rd(hs_slot_pkg::OFF_STATE, stExp(b, r));
      rd(hs_slot_pkg::OFF_OUT, {16'h0000, r, b});
      cmp("pins", {16'h0, r, b}, {16'h0, slotRstN, bdselN});
   endtask

   task automatic powerOn;
      chassisPwrOn <= 1'b1;
      repeat (4) @(posedge clk);
      chassisPwrOn <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      conclude();
   end

   initial begin
      rnd = $random(seed);
      present <= 8'h19 | (rnd[7:0] & 8'h7e);
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(hs_slot_pkg::OFF_CTRL, 32'h0, 32'h1);
      rd(hs_slot_pkg::OFF_BOOT, 32'hff, 32'hff);
      rd(hs_slot_pkg::OFF_MASK, 32'h0, 32'hffff);
      chkPins(1'b0);
      sick <= 8'h10;
      wr(hs_slot_pkg::OFF_BOOT, 32'h0);
      powerOn();
      chkPins(1'b0);
      wr(hs_slot_pkg::OFF_CTRL, 32'h1);
      chkPins(1'b1);
      boot = 8'($random(seed));
      wr(hs_slot_pkg::OFF_BOOT, {24'h0, boot});
      powerOn();
      swB = boot;
      chkPins(1'b1);
      boot = ~boot;
      wr(hs_slot_pkg::OFF_BOOT, {24'h0, boot});
      wr(hs_slot_pkg::OFF_CTRL, 32'h3);
      swB = boot;
      chkPins(1'b1);
      wr(hs_slot_pkg::OFF_BOOT, 32'hff);
      wr(hs_slot_pkg::OFF_CTRL, 32'h3);
      swB = 8'hff;
      chkPins(1'b1);
      swB = ~present;
      wr(hs_slot_pkg::OFF_STATE, {8'h5a, swR, 8'ha5, swB});
      chkPins(1'b1);
      swR = present & ~sick;
      wr(hs_slot_pkg::OFF_STATE, {8'h00, swR, 8'h00, swB});
      chkPins(1'b1);
      wr(hs_slot_pkg::OFF_STATUS, 32'hffff);
      swB = 8'hff;
      // Deselecting boards that are out of reset leaves an illegal slot state.
      wr(hs_slot_pkg::OFF_STATE, 32'h0000_00ff, 4'h1);
      chkPins(1'b1);
      rd(hs_slot_pkg::OFF_STATUS, {24'h0, swR & 8'h7e}, 32'hff);
      cmp("irq", 32'h0, {31'h0, irq});
      wr(hs_slot_pkg::OFF_MASK, 32'hff);
      repeat (3) @(posedge clk);
      cmp("irq", 32'h1, {31'h0, irq});
      swR = 8'h00;
      wr(hs_slot_pkg::OFF_STATE, 32'h0, 4'h4);
      repeat (5) @(posedge clk);
      wr(hs_slot_pkg::OFF_STATUS, 32'hffff);
      repeat (3) @(posedge clk);
      cmp("irq", 32'h0, {31'h0, irq});
      rd(hs_slot_pkg::OFF_STATUS, 32'h0, 32'hff);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         swB = rnd[7:0];
         swR = rnd[15:8];
         wr(hs_slot_pkg::OFF_STATE, {8'h00, swR, 8'h00, swB});
         chkPins(1'b1);
      end
      rd(8'h18, 32'h0, '1, hs_slot_pkg::RESP_SLVERR);
      rd(8'h09, 32'h0, '1, hs_slot_pkg::RESP_SLVERR);
      wr(8'h20, 32'hff, 4'hf, hs_slot_pkg::RESP_SLVERR);
      healthDelay <= 8'h01;
      wr(hs_slot_pkg::OFF_CTRL, 32'h0);
      chkPins(1'b0);
      conclude();
   end
endmodule // tb_hot_swap_slot_signal_ctrl
